// *** include/vdwm_pkg.sv ***
// Package for the video DRAM random-port cycle controller
`default_nettype none
package vdwm_pkg;
  // Avalon word offsets (byte addresses)
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_ADDR   = 4'h4;
  localparam logic [3:0] OFS_WDATA  = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  // Command codes written to CTRL[3:0]; bit 8 starts the cycle
  localparam int CMD_GO_BIT = 8;
  typedef enum logic [3:0] {
    VDWM_CMD_READ      = 4'h0,
    VDWM_CMD_WRITE     = 4'h1,
    VDWM_CMD_LATE_WR   = 4'h2,
    VDWM_CMD_NP_MWR    = 4'h3,
    VDWM_CMD_P_MWR     = 4'h4,
    VDWM_CMD_BLK_WR    = 4'h5,
    VDWM_CMD_NP_MBLK   = 4'h6,
    VDWM_CMD_P_MBLK    = 4'h7,
    VDWM_CMD_LOAD_MASK = 4'h8,
    VDWM_CMD_LOAD_COL  = 4'h9,
    VDWM_CMD_XFER      = 4'hA
  } vdwm_cmd_t;
  // Phase length in clocks (25 ns each), from 75 ns; each phase lasts PHASE_CNT+1 clocks, 100 ns
  localparam int PHASE_NS   = 75;
  localparam int CLK_NS     = 25;
  localparam int PHASE_CYC  = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PHASE_CNT = 4'(PHASE_CYC);
  localparam int ADDR_W = 9;
  localparam int DATA_W = 4;
  // Pins toward the memory; strobes are active low
  typedef struct packed {
    logic                row_strobe_n;
    logic                col_strobe_n;
    logic                transfer_or_output_select_n;
    logic                mask_or_write_select_n;
    logic                special_function_select;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_out;
    logic                dq_oe;
  } vdwm_pins_t;
endpackage : vdwm_pkg
`default_nettype wire

// *** src/vdwm_ctrl.sv ***
// Controller that drives the random port of a dual-port video DRAM
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`default_nettype none
module vdwm_ctrl (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Avalon-MM slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Memory random port
  output logic             o_row_strobe_n,
  output logic             o_col_strobe_n,
  output logic             o_transfer_or_output_select_n,
  output logic             o_mask_or_write_select_n,
  output logic             o_special_function_select,
  output logic [8:0]       o_addr,
  output logic [3:0]       o_random_data_lines_out,
  output logic             o_random_data_lines_oe,
  input  wire logic [3:0]  i_random_data_lines_in
);
  typedef enum logic [2:0] {ST_IDLE, ST_ROW, ST_COL, ST_LATE, ST_OE, ST_END} vdwm_state_t;
  typedef struct packed {
    vdwm_state_t          st;
    logic [3:0]           cnt;
    vdwm_pkg::vdwm_cmd_t  cmd;
    logic [17:0]          addr;
    logic [3:0]           wdata;
    logic [3:0]           mask;
    logic [3:0]           rdata;
    logic                 busy;
    logic                 ack;
    logic [31:0]          rd;
    vdwm_pkg::vdwm_pins_t pins;
  } vdwm_state_s_t;

  logic [1:0]    rst_sync_r;
  vdwm_state_s_t s_r;
  vdwm_state_s_t s_nxt;
  logic          rstn;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rstn = rst_sync_r[1];

  function automatic logic is_wr(input vdwm_pkg::vdwm_cmd_t c);
    return c != vdwm_pkg::VDWM_CMD_READ && c != vdwm_pkg::VDWM_CMD_XFER;
  endfunction

  always_comb begin
    logic bus_req;
    bus_req = (i_avs_read || i_avs_write) && !s_r.ack;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    // Slave answers one cycle after request is seen
    if (bus_req) begin
      s_nxt.ack = 1'b1;
      if (i_avs_write) begin
        case (i_avs_address)
          vdwm_pkg::OFS_CTRL: begin
            // Orders while busy are dropped; software polls status first
            if (i_avs_writedata[vdwm_pkg::CMD_GO_BIT] && !s_r.busy) begin
              s_nxt.cmd  = vdwm_pkg::vdwm_cmd_t'(i_avs_writedata[3:0]);
              s_nxt.busy = 1'b1;
              s_nxt.st   = ST_ROW;
              s_nxt.cnt  = vdwm_pkg::PHASE_CNT;
            end
          end
          vdwm_pkg::OFS_ADDR:  s_nxt.addr  = i_avs_writedata[17:0];
          vdwm_pkg::OFS_WDATA: begin
            s_nxt.wdata = i_avs_writedata[3:0];
            s_nxt.mask  = i_avs_writedata[11:8];
          end
          default: ;
        endcase
      end else begin
        case (i_avs_address)
          vdwm_pkg::OFS_CTRL:   s_nxt.rd = {28'h0, s_r.cmd};
          vdwm_pkg::OFS_ADDR:   s_nxt.rd = {14'h0, s_r.addr};
          vdwm_pkg::OFS_WDATA:  s_nxt.rd = {20'h0, s_r.mask, 4'h0, s_r.wdata};
          vdwm_pkg::OFS_STATUS: s_nxt.rd = {23'h0, s_r.busy, 4'h0, s_r.rdata};
          default:              s_nxt.rd = 32'h0;
        endcase
      end
    end
    if (s_r.cnt != 4'h0) begin
      s_nxt.cnt = s_r.cnt - 4'h1;
    end
    case (s_r.st)
      ST_IDLE: begin
        // Strobes high: other pins are free, nothing starts
        s_nxt.pins.row_strobe_n = 1'b1;
        s_nxt.pins.col_strobe_n = 1'b1;
        s_nxt.pins.transfer_or_output_select_n = 1'b1;
        s_nxt.pins.dq_oe = 1'b0;
      end
      ST_ROW: begin
        // Set up row address and row-time selects, then drop row strobe
        s_nxt.pins.addr = s_r.addr[17:9];
        s_nxt.pins.transfer_or_output_select_n = (s_r.cmd != vdwm_pkg::VDWM_CMD_XFER);
        case (s_r.cmd)
          vdwm_pkg::VDWM_CMD_NP_MWR, vdwm_pkg::VDWM_CMD_NP_MBLK: begin
            s_nxt.pins.mask_or_write_select_n = 1'b0;
            s_nxt.pins.special_function_select = 1'b0;
            s_nxt.pins.dq_out = s_r.mask;
            s_nxt.pins.dq_oe = 1'b1;
          end
          vdwm_pkg::VDWM_CMD_P_MWR, vdwm_pkg::VDWM_CMD_P_MBLK: begin
            s_nxt.pins.mask_or_write_select_n = 1'b0;
            s_nxt.pins.special_function_select = 1'b1;
          end
          vdwm_pkg::VDWM_CMD_LOAD_MASK, vdwm_pkg::VDWM_CMD_LOAD_COL: begin
            s_nxt.pins.mask_or_write_select_n = 1'b1;
            s_nxt.pins.special_function_select = 1'b1;
          end
          default: begin
            s_nxt.pins.mask_or_write_select_n = 1'b1;
            s_nxt.pins.special_function_select = 1'b0;
          end
        endcase
        if (s_r.cnt == 4'h0) begin
          s_nxt.pins.row_strobe_n = 1'b0;
          s_nxt.st  = ST_COL;
          s_nxt.cnt = vdwm_pkg::PHASE_CNT;
        end
      end
      ST_COL: begin
        // Column address; mask load ignores it, so zero is sent
        s_nxt.pins.addr = (s_r.cmd == vdwm_pkg::VDWM_CMD_LOAD_MASK) ? 9'h000 : s_r.addr[8:0];
        s_nxt.pins.special_function_select =
          (s_r.cmd == vdwm_pkg::VDWM_CMD_BLK_WR || s_r.cmd == vdwm_pkg::VDWM_CMD_NP_MBLK ||
           s_r.cmd == vdwm_pkg::VDWM_CMD_P_MBLK || s_r.cmd == vdwm_pkg::VDWM_CMD_LOAD_COL);
        // Early write: select low before column fall read keeps it high
        s_nxt.pins.mask_or_write_select_n = !(is_wr(s_r.cmd) && s_r.cmd != vdwm_pkg::VDWM_CMD_LATE_WR);
        s_nxt.pins.dq_out = s_r.wdata;
        s_nxt.pins.dq_oe  = is_wr(s_r.cmd);
        if (s_r.cnt == 4'h0) begin
          s_nxt.pins.col_strobe_n = 1'b0;
          s_nxt.cnt = vdwm_pkg::PHASE_CNT;
          if (s_r.cmd == vdwm_pkg::VDWM_CMD_LATE_WR) begin
            s_nxt.st = ST_LATE;
          end else if (s_r.cmd == vdwm_pkg::VDWM_CMD_READ) begin
            s_nxt.st = ST_OE;
          end else begin
            s_nxt.st = ST_END;
          end
        end
      end
      ST_LATE: begin
        // Select falls after column strobe
        s_nxt.pins.mask_or_write_select_n = 1'b0;
        s_nxt.pins.dq_oe = 1'b1;
        if (s_r.cnt == 4'h0) begin
          s_nxt.st  = ST_END;
          s_nxt.cnt = vdwm_pkg::PHASE_CNT;
        end
      end
      ST_OE: begin
        // Output enable falls well after row strobe sample at end
        s_nxt.pins.transfer_or_output_select_n = 1'b0;
        if (s_r.cnt == 4'h0) begin
          s_nxt.rdata = i_random_data_lines_in;
          s_nxt.st  = ST_END;
          s_nxt.cnt = vdwm_pkg::PHASE_CNT;
        end
      end
      ST_END: begin
        // Row strobe rise ends the cycle; device drops a nonpersistent mask
        s_nxt.pins.row_strobe_n = 1'b1;
        s_nxt.pins.col_strobe_n = 1'b1;
        s_nxt.pins.transfer_or_output_select_n = 1'b1;
        s_nxt.pins.mask_or_write_select_n = 1'b1;
        s_nxt.pins.dq_oe = 1'b0;
        if (s_r.cnt == 4'h0) begin
          s_nxt.st   = ST_IDLE;
          s_nxt.busy = 1'b0;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{st: ST_IDLE, cnt: 4'h0, cmd: vdwm_pkg::VDWM_CMD_READ, addr: 18'h0, wdata: 4'h0,
               mask: 4'h0, rdata: 4'h0, busy: 1'b0, ack: 1'b0, rd: 32'h0,
               pins: '{row_strobe_n: 1'b1, col_strobe_n: 1'b1, transfer_or_output_select_n: 1'b1,
                       mask_or_write_select_n: 1'b1, special_function_select: 1'b0,
                       addr: 9'h000, dq_out: 4'h0, dq_oe: 1'b0}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_avs_readdata                = s_r.rd;
  assign o_avs_waitrequest             = !s_r.ack;
  assign o_row_strobe_n                = s_r.pins.row_strobe_n;
  assign o_col_strobe_n                = s_r.pins.col_strobe_n;
  assign o_transfer_or_output_select_n = s_r.pins.transfer_or_output_select_n;
  assign o_mask_or_write_select_n      = s_r.pins.mask_or_write_select_n;
  assign o_special_function_select     = s_r.pins.special_function_select;
  assign o_addr                        = s_r.pins.addr;
  assign o_random_data_lines_out       = s_r.pins.dq_out;
  assign o_random_data_lines_oe        = s_r.pins.dq_oe;
endmodule // vdwm_ctrl
`default_nettype wire

// *** bench/vdwm_ctrl_assertions.sv ***
// Pin and bus checker for the video DRAM port controller
`default_nettype none
module vdwm_ctrl_chk (
  // Clock, reset and bus
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  // Memory pins
  input wire logic o_row_strobe_n,
  input wire logic o_col_strobe_n,
  input wire logic o_transfer_or_output_select_n,
  input wire logic o_mask_or_write_select_n,
  input wire logic o_random_data_lines_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic r = o_row_strobe_n;
  wire logic c = o_col_strobe_n;
  wire logic t = o_transfer_or_output_select_n;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_col_fall;
    ##[1:12] $fell(c);
  endsequence
  sel_setup_a: assert property ($fell(r) |-> $stable(o_mask_or_write_select_n) && $stable(t))
    else $error("select moved at row fall");
  col_in_row_a: assert property ($fell(c) |-> !r) else $error("column fell outside row");
  oe_late_a: assert property ($fell(t) && !r |-> !c) else $error("output enable too early");
  row_width_a: assert property ($fell(r) |-> !r [*4]) else $error("row phase too short");
  row_col_a: assert property ($fell(r) |-> s_col_fall) else $error("no column after row");
  row_end_a: assert property ($rose(r) |-> c) else $error("row ended with column low");
  no_clash_a: assert property (o_random_data_lines_oe && !r && !c |-> t) else $error("data clash");
  bus_ans_a: assert property ($rose(i_avs_read || i_avs_write) |=> !o_avs_waitrequest) else $error("late answer");
  bus_one_a: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest) else $error("long answer");
endmodule // vdwm_ctrl_chk
bind vdwm_ctrl vdwm_ctrl_chk u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_row_strobe_n(o_row_strobe_n), .o_col_strobe_n(o_col_strobe_n),
  .o_transfer_or_output_select_n(o_transfer_or_output_select_n),
  .o_mask_or_write_select_n(o_mask_or_write_select_n), .o_random_data_lines_oe(o_random_data_lines_oe));
`default_nettype wire

// *** bench/vdwm_vram_model.sv ***
// Behavioural model of the video DRAM random port
`default_nettype none
module vdwm_vram_model (
  // Strobes and selects
  input  wire logic       i_row_n,
  input  wire logic       i_col_n,
  input  wire logic       i_xfer_oe_n,
  input  wire logic       i_mask_we_n,
  input  wire logic       i_special,
  // Address and data
  input  wire logic [8:0] i_addr,
  input  wire logic [3:0] i_dq,
  output logic      [3:0] o_dq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] mem [512];
  logic [3:0] mask = 4'h0, color = 4'h0, m, held = 4'h0;
  logic [8:0] col;
  logic xf, msk, pm, ld, bw;
  // Released lines show the inverse of the last word, never a stale copy
  assign o_dq = (!i_row_n && !i_col_n && !i_xfer_oe_n && i_mask_we_n && !xf) ? mem[col] : ~held;
  always @(posedge i_xfer_oe_n) held = mem[col];
  always @(negedge i_row_n) begin
    xf = !i_xfer_oe_n;
    msk = !i_mask_we_n && !xf;
    pm = msk && i_special;
    ld = !xf && i_mask_we_n && i_special;
    if (msk && !i_special) mask = i_dq;
  end
  always @(posedge i_row_n) if (msk && !pm) mask = 4'h0;
  always @(negedge i_col_n) if (!i_row_n && !xf) begin
    col = i_addr;
    bw = i_special;
    if (ld && i_special) color = i_dq;
    else if (ld) mask = i_dq;
    else if (!i_mask_we_n) wr();
  end
  always @(negedge i_mask_we_n) if (!i_col_n && !i_row_n && !xf && !ld) wr();
  task automatic wr();
    m = msk ? mask : 4'hF;
    if (bw) begin
      for (int j = 0; j < 4; j++) if (i_dq[j]) mem[{col[8:2], 2'(j)}] = (mem[{col[8:2], 2'(j)}] & ~m) | (color & m);
    end else mem[col] = (mem[col] & ~m) | (i_dq & m);
  endtask
endmodule // vdwm_vram_model
`default_nettype wire

// *** bench/vdwm_ctrl_tb.sv ***
// Self-checking bench for the video DRAM port controller
`default_nettype none
module vdwm_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic [3:0] i_avs_address = 4'h0, xm [8], xmask = 4'h0, xcol = 4'h0, dq_dev, o_random_data_lines_out;
  logic [31:0] i_avs_writedata = 32'h0, rd, o_avs_readdata;
  logic o_avs_waitrequest, o_row_strobe_n, o_col_strobe_n, o_transfer_or_output_select_n;
  logic o_mask_or_write_select_n, o_special_function_select, o_random_data_lines_oe;
  logic [8:0] o_addr;
  int errors = 0, num_checks = 0, seed = 32'hb57b;
  wire logic [3:0] dq = o_random_data_lines_oe ? o_random_data_lines_out : dq_dev;
  vdwm_ctrl dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_row_strobe_n(o_row_strobe_n), .o_col_strobe_n(o_col_strobe_n),
    .o_transfer_or_output_select_n(o_transfer_or_output_select_n),
    .o_mask_or_write_select_n(o_mask_or_write_select_n), .o_special_function_select(o_special_function_select),
    .o_addr(o_addr), .o_random_data_lines_out(o_random_data_lines_out),
    .o_random_data_lines_oe(o_random_data_lines_oe), .i_random_data_lines_in(dq));
  vdwm_vram_model u_mem (.i_row_n(o_row_strobe_n), .i_col_n(o_col_strobe_n), .i_xfer_oe_n(o_transfer_or_output_select_n),
    .i_mask_we_n(o_mask_or_write_select_n), .i_special(o_special_function_select), .i_addr(o_addr), .i_dq(dq),
    .o_dq(dq_dev));
  always #12.5 i_clk = ~i_clk;
  task automatic results();
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic ck(string nm, logic [31:0] e, logic [31:0] v);
    num_checks++;
    if (v !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic bus(logic wr, logic [3:0] ad, logic [31:0] wd);
    int n = 0;
    @(posedge i_clk);
    i_avs_address <= ad;
    i_avs_writedata <= wd;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    do begin @(posedge i_clk); n++; end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin errors++; results(); end
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  function automatic void upd(logic [3:0] c, logic [2:0] a, logic [3:0] d, logic [3:0] k);
    logic [3:0] m;
    m = (c == 4'h3 || c == 4'h6) ? k : (c == 4'h4 || c == 4'h7) ? xmask : 4'hF;
    if (c inside {[1:4]}) xm[a] = (xm[a] & ~m) | (d & m);
    if (c inside {[5:7]}) for (int j = 0; j < 4; j++) if (d[j]) xm[{a[2], 2'(j)}] = (xm[{a[2], 2'(j)}] & ~m) | (xcol & m);
    if (c == 4'h8) xmask = d;
    if (c == 4'h9) xcol = d;
    if (c == 4'h3 || c == 4'h6) xmask = 4'h0;
  endfunction
  task automatic wt();
    int n = 0;
    do begin bus(1'b0, vdwm_pkg::OFS_STATUS, 32'h0); n++; end while (rd[8] !== 1'b0 && n < 60);
    if (n >= 60) begin errors++; results(); end
  endtask
  task automatic go(logic [3:0] c, logic [8:0] a, logic [3:0] d, logic [3:0] k);
    bus(1'b1, vdwm_pkg::OFS_ADDR, {23'h0, a});
    bus(1'b1, vdwm_pkg::OFS_WDATA, {20'h0, k, 4'h0, d});
    bus(1'b1, vdwm_pkg::OFS_CTRL, {23'h0, 1'b1, 4'h0, c});
    wt();
    upd(c, a[2:0], d, k);
  endtask
  // Idle pins: strobes and active-low selects high, special select low, lines released, bus waiting
  task automatic pins_idle();
    logic [31:0] p;
    p = {16'h0, o_addr, o_special_function_select, o_avs_waitrequest, o_row_strobe_n, o_col_strobe_n,
         o_transfer_or_output_select_n, o_mask_or_write_select_n, o_random_data_lines_oe};
    ck("pins after reset", 32'h0000003E, p);
  endtask
  task automatic vfy();
    for (int i = 0; i < 8; i++) begin
      go(4'h0, 9'(i), 4'h0, 4'h0);
      ck("read word", {28'h0, xm[i]}, {28'h0, rd[3:0]});
    end
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    pins_idle();
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    bus(1'b0, 4'h1, 32'h0);
    ck("unmapped read", 32'h0, rd);
    bus(1'b1, vdwm_pkg::OFS_WDATA, 32'hFFFFFFFF);
    bus(1'b0, vdwm_pkg::OFS_WDATA, 32'h0);
    ck("data readback", 32'h00000F0F, rd);
    for (int i = 0; i < 8; i++) go(4'h1, 9'(i), 4'(i), 4'h0);
    go(4'h8, 9'h1F5, 4'h5, 4'h0);
    go(4'h9, 9'h0, 4'hA, 4'h0);
    go(4'h4, 9'h2, 4'hF, 4'h0);
    go(4'h1, 9'h3, 4'hC, 4'h0);
    go(4'h4, 9'h3, 4'h3, 4'h0);
    go(4'h5, 9'h4, 4'h5, 4'h0);
    go(4'h7, 9'h4, 4'hA, 4'h0);
    go(4'h2, 9'h6, 4'h9, 4'h0);
    go(4'h6, 9'h0, 4'h3, 4'h9);
    go(4'h3, 9'h1, 4'h9, 4'h6);
    go(4'h4, 9'h1, 4'hF, 4'h0);
    go(4'hA, 9'h0, 4'hF, 4'h0);
    bus(1'b0, vdwm_pkg::OFS_CTRL, 32'h0);
    ck("command readback", 32'h0000000A, rd);
    // A second order while busy must be dropped
    bus(1'b1, vdwm_pkg::OFS_CTRL, 32'h00000100);
    bus(1'b1, vdwm_pkg::OFS_CTRL, 32'h00000101);
    bus(1'b0, vdwm_pkg::OFS_CTRL, 32'h0);
    ck("order while busy", 32'h0, rd);
    wt();
    vfy();
    bus(1'b1, vdwm_pkg::OFS_ADDR, 32'hFFFFFFFF);
    bus(1'b0, vdwm_pkg::OFS_ADDR, 32'h0);
    ck("address readback", 32'h0003FFFF, rd);
    i_resetn <= 1'b0;
    @(posedge i_clk);
    pins_idle();
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < 30; i++) begin
      go(4'($unsigned($random(seed)) % 11), 9'($unsigned($random(seed)) % 8), 4'($random(seed)), 4'($random(seed)));
      vfy();
    end
    results();
  end
endmodule // vdwm_ctrl_tb
`default_nettype wire
